/* rtl/cbpc_addr_dec.sv */
// Purpose: Decode two tri-level pins into one bus address
// Assumes: Pins already encoded as low, mid or high
// Notes:   Pure combinational table
`timescale 1ns/1ps
module cbpc_addr_dec
(
  // Pin levels
  input  wire logic [1:0] pin_hi,
  input  wire logic [1:0] pin_lo,
  // Decoded address
  output logic      [7:0] addr
);

  // Nine-entry lookup; illegal code falls to the LL address
  always_comb
  begin
    addr = cbpc_pkg::ADDR_LL;
    unique case ({pin_hi, pin_lo})
      {cbpc_pkg::TRI_L, cbpc_pkg::TRI_M}: addr = cbpc_pkg::ADDR_LM; // [RULE14]
      {cbpc_pkg::TRI_L, cbpc_pkg::TRI_H}: addr = cbpc_pkg::ADDR_LH;
      {cbpc_pkg::TRI_M, cbpc_pkg::TRI_L}: addr = cbpc_pkg::ADDR_ML;
      {cbpc_pkg::TRI_M, cbpc_pkg::TRI_M}: addr = cbpc_pkg::ADDR_MM;
      {cbpc_pkg::TRI_M, cbpc_pkg::TRI_H}: addr = cbpc_pkg::ADDR_MH;
      {cbpc_pkg::TRI_H, cbpc_pkg::TRI_L}: addr = cbpc_pkg::ADDR_HL;
      {cbpc_pkg::TRI_H, cbpc_pkg::TRI_M}: addr = cbpc_pkg::ADDR_HM;
      {cbpc_pkg::TRI_H, cbpc_pkg::TRI_H}: addr = cbpc_pkg::ADDR_HH;
      default:                            addr = cbpc_pkg::ADDR_LL;
    endcase
  end

endmodule

/* rtl/cbpc_pkg.sv */
// Purpose: Shared constants and types for the clock buffer power control
// Assumes: pclk at 250 MHz, APB with 32-bit data
// Notes:   Register offsets are byte addresses
package cbpc_pkg;

  // Clock rate and timing
  localparam int unsigned CLK_MHZ          = 250;
  localparam int unsigned LOCK_TIME_US_X10 = 18000; // 1.8 ms in 0.1 us units
  localparam int unsigned RESUME_TIME_US   = 300;   // Restart bound, us
  localparam int unsigned LOCK_CYCLES      =
    (LOCK_TIME_US_X10 * CLK_MHZ) / 10;
  localparam int unsigned RESUME_CYCLES    = RESUME_TIME_US * CLK_MHZ;

  // Outputs
  localparam int unsigned NUM_DIF   = 19;
  localparam int unsigned OE_GRP_LO = 5;
  localparam int unsigned OE_GRP_HI = 12;

  // Register offsets
  localparam logic [7:0] OFS_CFG0   = 8'h00;
  localparam logic [7:0] OFS_CTRL   = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;

  // Byte 0 field positions
  localparam int unsigned B0_RB_HI  = 7;
  localparam int unsigned B0_RB_LO  = 6;
  localparam int unsigned B0_OVR_EN = 3;
  localparam int unsigned B0_OVR_HI = 2;
  localparam int unsigned B0_OVR_LO = 1;

  // Reset values
  localparam logic [7:0] CFG0_RST = 8'h00;
  localparam logic       BUS_EN_RST = 1'b1;

  // Tri-level pin encoding
  localparam logic [1:0] TRI_L = 2'h0;
  localparam logic [1:0] TRI_M = 2'h1;
  localparam logic [1:0] TRI_H = 2'h2;

  // PLL mode readback codes
  localparam logic [1:0] PLL_LBW    = 2'h0;
  localparam logic [1:0] PLL_BYPASS = 2'h1;
  localparam logic [1:0] PLL_HBW    = 2'h3;

  // Bus address table
  localparam logic [7:0] ADDR_LL = 8'hD8;
  localparam logic [7:0] ADDR_LM = 8'hDA;
  localparam logic [7:0] ADDR_LH = 8'hDE;
  localparam logic [7:0] ADDR_ML = 8'hC2;
  localparam logic [7:0] ADDR_MM = 8'hC4;
  localparam logic [7:0] ADDR_MH = 8'hC6;
  localparam logic [7:0] ADDR_HL = 8'hCA;
  localparam logic [7:0] ADDR_HM = 8'hCC;
  localparam logic [7:0] ADDR_HH = 8'hCE;

  // Latched strap set
  typedef struct packed {
    logic       freq_sel;
    logic [1:0] addr_hi;
    logic [1:0] addr_lo;
    logic [1:0] bw;
  } cbpc_strap_type;

endpackage

/* rtl/cbpc_sync.sv */
// Purpose: Two-flop synchroniser for one asynchronous level
// Assumes: Single clock domain on the receiving side
// Notes:   First stage is read only by the second stage
`timescale 1ns/1ps
module cbpc_sync
(
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // Data
  input  wire logic d,
  output logic      q
);

  logic meta_ff;   // Metastable stage

  // Plain two-stage shift
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_ff <= 1'b0;
      q       <= 1'b0;
    end
    else
    begin
      meta_ff <= d;
      q       <= meta_ff;
    end
  end

endmodule

/* rtl/cbpc_top.sv */
// Purpose: Power-good/power-down sequencing and output gating of a
//          differential clock fan-out buffer, with APB config registers
// Assumes: pclk is the reference clock domain; diff_clock_out edges are
//          represented by one-cycle rise/fall enable pulses from inputs
// Notes:   presetn models full power removal; straps latch once only
//
// Our own choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps

// How it works
// RULE1: First power-good rise latches all straps
// RULE2: Afterwards the pin means power-down, active low
// RULE3: Two low samples, tri-state on next fall
// RULE4: Outputs disabled before oscillator stops
// RULE5: Power-good low tri-states everything, PLL off
// RULE6: Enable bit and OE pin gate outputs
// RULE7: Tri-stated outputs left undriven, pulled low
// RULE8: Outputs locked within 1.8 ms of start
// RULE9: Stopped outputs driven within 300 us
// RULE10: Restart clocks cleanly after power-down release
// RULE11: Host asserts power-down before stopping input
// RULE12: Frequency strap 0 is 133, 1 is 100
// RULE13: Frequency changes switch outputs glitch free
// RULE14: Two tri-level pins give nine addresses
// RULE15: Bandwidth strap readback in byte 0 bits 7:6
// RULE16: Override bits 2:1 honoured only with bit 3
// RULE17: Power-down tri-states bus pins, keeps config
// RULE18: Straps never resampled until full power-up
module cbpc_top
#(
  parameter int unsigned LOCK_CYC   = cbpc_pkg::LOCK_CYCLES,
  parameter int unsigned RESUME_CYC = cbpc_pkg::RESUME_CYCLES
)
(
  // Clock and reset
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  // APB slave
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [7:0]              paddr,
  input  wire logic [31:0]             pwdata,
  output logic      [31:0]             prdata,
  output logic                         pready,
  output logic                         pslverr,
  // Power-good / power-down pin (asynchronous)
  input  wire logic                    power_good_strobe,
  // Straps (asynchronous pins)
  input  wire logic                    freq_select_strap,
  input  wire logic [1:0]              bus_addr_pin_high,
  input  wire logic [1:0]              bus_addr_pin_low,
  input  wire logic [1:0]              pll_bandwidth_strap,
  // Output enable pin, active low, and input clock presence
  input  wire logic                    oe_grp_n,
  input  wire logic                    clk_in_valid,
  // Output clock edge pulses from the output stage
  input  wire logic                    dif_rise,
  input  wire logic                    dif_fall,
  // Output stage control
  output logic [cbpc_pkg::NUM_DIF-1:0] diff_clock_out_oe,
  output logic                         feedback_clock_out_oe,
  output logic                         osc_run,
  output logic                         pll_locked,
  output logic [1:0]                   pll_mode,
  output logic                         freq_sel,
  output logic [7:0]                   bus_addr,
  output logic                         bus_pins_oe
);

  // Synchronised pin levels
  logic       pg_s;
  logic       fs_s;
  logic       oe_n_s;
  logic       clkv_s;
  logic [1:0] ah_s;
  logic [1:0] al_s;
  logic [1:0] bw_s;
  logic [7:0] addr_dec;

  // Power sequencing state
  typedef enum logic [4:0]
  {
    ST_OFF    = 5'h01,  // Waiting for first power-good
    ST_LOCK   = 5'h02,  // PLL acquiring lock
    ST_RUN    = 5'h04,  // Normal operation
    ST_STOPO  = 5'h08,  // Outputs off, oscillator still running
    ST_POWER_DOWN_N  = 5'h10   // Oscillator stopped
  } cbpc_state_type;

  cbpc_state_type             state_ff;
  cbpc_state_type             nxt_state;
  logic                       latched_ff;    // Straps have been taken
  cbpc_pkg::cbpc_strap_type   strap_ff;      // Latched strap set
  logic [1:0]                 low_cnt_ff;    // Low samples on rising edges
  logic                       pd_req_ff;     // Two lows seen
  logic [31:0]                tmr_ff;        // Lock / resume timer
  logic [7:0]                 cfg0_ff;       // Byte 0 writable bits
  logic                       bus_en_ff;     // Output enable bit
  logic                       outs_on;       // Outputs allowed to run

  // Pin synchronisers, one per asynchronous bit
  cbpc_sync u_sync_pg (.clk(pclk), .rst_n(presetn),
                       .d(power_good_strobe), .q(pg_s));
  cbpc_sync u_sync_fs (.clk(pclk), .rst_n(presetn),
                       .d(freq_select_strap), .q(fs_s));
  cbpc_sync u_sync_oe (.clk(pclk), .rst_n(presetn),
                       .d(oe_grp_n), .q(oe_n_s));
  cbpc_sync u_sync_cv (.clk(pclk), .rst_n(presetn),
                       .d(clk_in_valid), .q(clkv_s));

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++)
    begin : g_sync2
      cbpc_sync u_ah (.clk(pclk), .rst_n(presetn),
                      .d(bus_addr_pin_high[gi]), .q(ah_s[gi]));
      cbpc_sync u_al (.clk(pclk), .rst_n(presetn),
                      .d(bus_addr_pin_low[gi]), .q(al_s[gi]));
      cbpc_sync u_bw (.clk(pclk), .rst_n(presetn),
                      .d(pll_bandwidth_strap[gi]), .q(bw_s[gi]));
    end
  endgenerate

  // Address decode of the latched pins
  cbpc_addr_dec u_dec (.pin_hi(strap_ff.addr_hi), .pin_lo(strap_ff.addr_lo),
                       .addr(addr_dec));

  // Strap latch: once only, on first power-good rise
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      latched_ff <= 1'b0;
      strap_ff   <= '0;
    end
    else if (!latched_ff && pg_s && clkv_s)
    begin
      latched_ff <= 1'b1;                                 // [RULE2]
      strap_ff   <= '{freq_sel: fs_s, addr_hi: ah_s,      // [RULE1]
                      addr_lo: al_s, bw: bw_s};           // [RULE18]
    end
  end

  // Power-down filter: two lows on consecutive output rising edges
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      low_cnt_ff <= 2'h0;
      pd_req_ff  <= 1'b0;
    end
    else if (!latched_ff || pg_s)
    begin
      // High level or not yet latched: no request
      low_cnt_ff <= 2'h0;
      pd_req_ff  <= 1'b0;
    end
    else if (dif_rise && low_cnt_ff != 2'h2)
    begin
      low_cnt_ff <= low_cnt_ff + 2'h1;                    // [RULE3]
      pd_req_ff  <= (low_cnt_ff == 2'h1);
    end
  end

  // Sequencer next state
  always_comb
  begin
    nxt_state = state_ff;
    unique case (state_ff)
      ST_OFF:
        if (latched_ff && pg_s && clkv_s)
          nxt_state = ST_LOCK;
      ST_LOCK:
        if (pd_req_ff && dif_fall)
          nxt_state = ST_STOPO;
        else if (tmr_ff == 32'h0)
          nxt_state = ST_RUN;                             // [RULE8]
      ST_RUN:
        // Tri-state only on the falling edge after two lows
        if (pd_req_ff && dif_fall)
          nxt_state = ST_STOPO;                           // [RULE3]
      ST_STOPO:
        nxt_state = ST_POWER_DOWN_N;                             // [RULE4]
      ST_POWER_DOWN_N:
        // Release restarts oscillator and relocks
        if (pg_s && clkv_s)
          nxt_state = ST_LOCK;                            // [RULE10]
      default:
        nxt_state = ST_OFF;
    endcase
  end

  // Sequencer state register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      state_ff <= ST_OFF;
    else
      state_ff <= nxt_state;
  end

  // Lock timer; after a power-down the shorter resume bound applies
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      tmr_ff <= 32'h0;
    else if (state_ff == ST_OFF && nxt_state == ST_LOCK)
      tmr_ff <= 32'(LOCK_CYC - 1);                        // [RULE8]
    else if (state_ff == ST_POWER_DOWN_N && nxt_state == ST_LOCK)
      tmr_ff <= 32'(RESUME_CYC - 1);                      // [RULE9]
    else if (state_ff == ST_LOCK && tmr_ff != 32'h0)
      tmr_ff <= tmr_ff - 32'h1;
  end

  assign outs_on = (state_ff == ST_RUN);

  // Output enables; off means undriven, terminations pull low
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      diff_clock_out_oe     <= '0;                        // [RULE5]
      feedback_clock_out_oe <= 1'b0;
    end
    else
    begin
      feedback_clock_out_oe <= outs_on && (nxt_state == ST_RUN);
      for (int i = 0; i < cbpc_pkg::NUM_DIF; i++)
      begin
        // Enable bit off holds all 19 diff outputs undriven; group pin high holds outputs 5 to 12 undriven
        if (!outs_on || nxt_state != ST_RUN || !bus_en_ff)
          diff_clock_out_oe[i] <= 1'b0;                   // [RULE7]
        else if (i >= cbpc_pkg::OE_GRP_LO && i <= cbpc_pkg::OE_GRP_HI)
          diff_clock_out_oe[i] <= !oe_n_s;                // [RULE6]
        else
          diff_clock_out_oe[i] <= 1'b1;
      end
    end
  end

  // Oscillator, lock, bus pins; oscillator drops one cycle after outputs
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      osc_run     <= 1'b0;
      pll_locked  <= 1'b0;
      bus_pins_oe <= 1'b0;
    end
    else
    begin
      osc_run     <= (nxt_state != ST_OFF) && (nxt_state != ST_POWER_DOWN_N); // [RULE4]
      pll_locked  <= (nxt_state == ST_RUN);
      bus_pins_oe <= (nxt_state != ST_OFF) && (nxt_state != ST_POWER_DOWN_N); // [RULE17]
    end
  end

  // Mode, frequency and address outputs; frequency changes only via
  // the latch, which happens while outputs are still off
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pll_mode <= cbpc_pkg::PLL_LBW;
      freq_sel <= 1'b0;
      bus_addr <= cbpc_pkg::ADDR_LL;
    end
    else
    begin
      if (cfg0_ff[cbpc_pkg::B0_OVR_EN])
        pll_mode <= cfg0_ff[cbpc_pkg::B0_OVR_HI:cbpc_pkg::B0_OVR_LO]; // [RULE16]
      else
        pll_mode <= bw_code(strap_ff.bw);
      if (!outs_on)
        freq_sel <= strap_ff.freq_sel;                    // [RULE12] [RULE13]
      bus_addr <= addr_dec;                               // [RULE14]
    end
  end

  // Tri-level strap to readback code
  function automatic logic [1:0] bw_code(input logic [1:0] lvl);
    logic [1:0] r;
    r = cbpc_pkg::PLL_LBW;
    if (lvl == cbpc_pkg::TRI_M)
      r = cbpc_pkg::PLL_BYPASS;
    else if (lvl == cbpc_pkg::TRI_H)
      r = cbpc_pkg::PLL_HBW;
    return r;                                             // [RULE15]
  endfunction

  // APB writes; configuration survives power-down
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cfg0_ff   <= cbpc_pkg::CFG0_RST;
      bus_en_ff <= cbpc_pkg::BUS_EN_RST;
    end
    else if (psel && penable && pwrite)
    begin
      if (paddr == cbpc_pkg::OFS_CFG0)
      begin
        cfg0_ff[cbpc_pkg::B0_OVR_EN] <= pwdata[cbpc_pkg::B0_OVR_EN];
        // Mode bits move only when override already enabled
        if (cfg0_ff[cbpc_pkg::B0_OVR_EN])
          cfg0_ff[cbpc_pkg::B0_OVR_HI:cbpc_pkg::B0_OVR_LO] <=
            pwdata[cbpc_pkg::B0_OVR_HI:cbpc_pkg::B0_OVR_LO];       // [RULE16]
      end
      else if (paddr == cbpc_pkg::OFS_CTRL)
        bus_en_ff <= pwdata[0];
    end
  end

  // APB read data and zero-wait ready; unmapped gives slave error
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata  <= 32'h0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready  <= psel && !penable;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
      if (psel && !penable)
      begin
        unique case (paddr)
          cbpc_pkg::OFS_CFG0:
            prdata <= {24'h0, bw_code(strap_ff.bw),       // [RULE15]
                       2'h0, cfg0_ff[3:1], 1'b0};
          cbpc_pkg::OFS_CTRL:
            prdata <= {31'h0, bus_en_ff};
          cbpc_pkg::OFS_STATUS:
            prdata <= {19'h0, bus_addr, state_ff};
          default:
            pslverr <= 1'b1;
        endcase
      end
    end
  end

endmodule

/* tb/cbpc_monitor.sv */
// Purpose: Concurrent checks on the clock buffer power control ports
// Assumes: One clock domain; presetn is asynchronous, active low
// Notes:   Bound to cbpc_top from the bench top file
`timescale 1ns/1ps
module cbpc_monitor
(
  // Clock and reset
  input wire logic                         pclk,
  input wire logic                         presetn,
  // APB handshake
  input wire logic                         psel,
  input wire logic                         penable,
  input wire logic                         pready,
  // Output edge pulse
  input wire logic                         dif_fall,
  // Output stage control
  input wire logic [cbpc_pkg::NUM_DIF-1:0] diff_clock_out_oe,
  input wire logic                         feedback_clock_out_oe,
  input wire logic                         osc_run,
  input wire logic                         pll_locked,
  input wire logic                         bus_pins_oe,
  input wire logic                         freq_sel,
  input wire logic [7:0]                   bus_addr
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // Outputs must be quiet a cycle before the oscillator stops
  stop_order_a: assert property (
    $fell(osc_run) |-> $past(feedback_clock_out_oe) == 1'b0)
    else $error("oscillator stopped with outputs driven");
  // Tri-state only lands just after a falling output edge
  fall_edge_a: assert property (
    $fell(feedback_clock_out_oe) |-> $past(dif_fall))
    else $error("outputs stopped away from a falling edge");
  // Nothing driven while the oscillator is off
  quiet_off_a: assert property (
    !osc_run |-> diff_clock_out_oe == '0 && !feedback_clock_out_oe)
    else $error("output driven with oscillator off");
  // Gated group and the rest each switch as one
  group_uniform_a: assert property (
    diff_clock_out_oe[12:5] inside {8'h00, 8'hFF} &&
    {diff_clock_out_oe[18:13], diff_clock_out_oe[4:0]}
      inside {11'h000, 11'h7FF})
    else $error("output group split");
  // Group pin only ever removes outputs 5 to 12
  group_subset_a: assert property (
    |diff_clock_out_oe[12:5] |-> &diff_clock_out_oe)
    else $error("group driven while others off");
  // Feedback runs whenever any output runs, and only when locked
  fb_lock_a: assert property (
    feedback_clock_out_oe || diff_clock_out_oe != '0
      |-> feedback_clock_out_oe && pll_locked && osc_run)
    else $error("output driven without feedback or lock");
  // Bus pins released together with the oscillator
  bus_quiet_a: assert property (
    $fell(osc_run) |-> $fell(bus_pins_oe))
    else $error("bus pins not released at power-down");
  // Latched straps never move once running
  strap_hold_a: assert property (
    $past(pll_locked) |-> $stable(freq_sel) && $stable(bus_addr))
    else $error("latched strap changed");
  // Slave answers in the access cycle without waits
  apb_answer_a: assert property (
    psel && !penable |=> pready ##1 !pready)
    else $error("no ready in access cycle");
endmodule

/* tb/cbpc_ref_src.sv */
// Purpose: Reference clock source at the far side of the block
// Assumes: Output clock edges are modelled as pulses on pclk
// Notes:   Edges stand still while the source is stopped
`timescale 1ns/1ps
module cbpc_ref_src
(
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // Host controls
  input  wire logic run_req,
  input  wire logic power_good_strobe,
  // Clock presence and edge pulses
  output logic      clk_in_valid,
  output logic      dif_rise,
  output logic      dif_fall
);
  logic [1:0] phase_ff; // Position in the output period
  logic       live;     // Source running

  // Refuses to stop while power-down is not asserted, so no glitch
  assign live = run_req | power_good_strobe;

  // Period counter, frozen while stopped
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      phase_ff <= 2'h0;
    else if (live)
      phase_ff <= phase_ff + 2'h1;
  end

  // Rise at phase 0, fall at phase 2
  assign clk_in_valid = live;
  assign dif_rise     = live && phase_ff == 2'h0;
  assign dif_fall     = live && phase_ff == 2'h2;
endmodule

/* tb/clock_buffer_power_control_bench.sv */
// Purpose: Self-checking bench for the clock buffer power control
// Assumes: Shortened lock and resume counts
// Notes:   Straps are relatched through a full reset between cases
`timescale 1ns/1ps
module clock_buffer_power_control_bench;
  localparam int unsigned LOCK = 20; // Shortened lock count
  localparam int unsigned RES  = 10; // Shortened resume count
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic        pg, fsel, ogn, run, civ, rise, fall, err;
  logic        fb, osc, lck, fs, bpo;
  logic [1:0]  ahi, alo, bw, pmode;
  logic [7:0]  paddr, baddr;
  logic [31:0] pwdata, prdata, rd;
  logic [18:0] doe;
  int          n, cyc, miscompares, checks_done;
  logic [7:0]  atab [9] = '{8'hD8, 8'hDA, 8'hDE, 8'hC2, 8'hC4, 8'hC6,
                           8'hCA, 8'hCC, 8'hCE};
  logic [1:0]  btab [3] = '{2'h0, 2'h1, 2'h3};

  cbpc_top #(.LOCK_CYC(LOCK), .RESUME_CYC(RES)) dut_u (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .power_good_strobe(pg), .freq_select_strap(fsel),
    .bus_addr_pin_high(ahi), .bus_addr_pin_low(alo),
    .pll_bandwidth_strap(bw), .oe_grp_n(ogn), .clk_in_valid(civ),
    .dif_rise(rise), .dif_fall(fall), .diff_clock_out_oe(doe),
    .feedback_clock_out_oe(fb), .osc_run(osc), .pll_locked(lck),
    .pll_mode(pmode), .freq_sel(fs), .bus_addr(baddr), .bus_pins_oe(bpo));
  cbpc_ref_src src_u (.pclk, .presetn, .run_req(run),
    .power_good_strobe(pg), .clk_in_valid(civ), .dif_rise(rise),
    .dif_fall(fall));

  // Free-running 250 MHz clock
  initial
  begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  // Cycle ceiling cuts a hang short
  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      miscompares++;
      end_of_test();
    end
  end

  // Compare and count
  task automatic chk(string what, logic [32:0] seen, logic [32:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One APB transfer, then two idle edges so registered effects settle
  task automatic apb(logic wr, logic [7:0] a, logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // No bound of its own; pready or the bench ceiling ends this wait
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    repeat (2) @(posedge pclk);
  endtask

  // Bounded wait for lock, cycle count left in n
  task automatic wait_lock();
    n = 0;
    while (lck !== 1'b1 && n < 1000)
    begin
      @(posedge pclk);
      n++;
    end
  endtask

  // Full power removal, new straps, then power good
  task automatic boot(logic f, logic [1:0] h, logic [1:0] l, logic [1:0] b);
    presetn <= 1'b0;
    pg <= 1'b0;
    fsel <= f;
    ahi <= h;
    alo <= l;
    bw <= b;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    pg <= 1'b1;
    wait_lock();
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // Main sequence
  initial
  begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {pg, fsel, ahi, alo, bw, ogn, err} = '0;
    {miscompares, checks_done, cyc} = '0;
    run = 1'b1;
    presetn = 1'b0;
    @(posedge pclk);
    // Every address code, bandwidth code and frequency strap
    for (int i = 0; i < 9; i++)
    begin
      boot(i[0], 2'(i / 3), 2'(i % 3), 2'(i % 3));
      chk("lock", n >= LOCK && n <= LOCK + 8, 1);
      chk("addr", baddr, atab[i]);
      chk("freq", fs, i[0]);
      apb(1'b0, cbpc_pkg::OFS_CFG0, 32'h0);
      chk("bw", rd[7:6], btab[i % 3]);
      chk("run", {fb, doe}, 20'hFFFFF);
    end
    apb(1'b0, cbpc_pkg::OFS_CTRL, 32'h0);
    chk("ctrl", rd, 32'h1);
    $display("strap test done");
    // Group pin and enable bit
    ogn <= 1'b1;
    repeat (5) @(posedge pclk);
    chk("grp", {fb, doe}, 20'hFE01F);
    apb(1'b1, cbpc_pkg::OFS_CTRL, 32'h0);
    chk("en", {fb, doe}, 20'h80000);
    ogn <= 1'b0;
    apb(1'b1, cbpc_pkg::OFS_CTRL, 32'h1);
    repeat (4) @(posedge pclk);
    chk("all", {fb, doe}, 20'hFFFFF);
    $display("gating test done");
    // Mode override needs its enable first
    apb(1'b1, cbpc_pkg::OFS_CFG0, 32'h0A);
    chk("ovr0", pmode, 2'h0);
    apb(1'b1, cbpc_pkg::OFS_CFG0, 32'h0C);
    chk("ovr1", pmode, 2'h2);
    apb(1'b0, cbpc_pkg::OFS_CFG0, 32'h0);
    chk("rb", rd[7:6], 2'h3);
    chk("ovr bits", rd[3:1], 3'h6);
    apb(1'b0, cbpc_pkg::OFS_STATUS, 32'h0);
    chk("status", rd, 32'h19C4);
    apb(1'b0, 8'h10, 32'h0);
    chk("unmapped", {err, rd}, 33'h100000000);
    $display("override test done");
    // Power-down waits for two rises, stops on a fall
    pg <= 1'b0;
    repeat (3) @(posedge pclk);
    chk("hold", fb, 1'b1);
    n = 0;
    while (fb !== 1'b0 && n < 40)
    begin
      @(posedge pclk);
      n++;
    end
    chk("off", doe, 19'h0);
    @(posedge pclk);
    chk("osc", {osc, bpo}, 2'h0);
    run <= 1'b0;
    fsel <= 1'b1;
    ahi <= 2'h0;
    repeat (10) @(posedge pclk);
    chk("keep", {pmode, baddr}, {2'h2, 8'hCE});
    // Release restarts without relatching straps
    run <= 1'b1;
    @(posedge pclk);
    pg <= 1'b1;
    wait_lock();
    chk("resume", n >= RES && n <= RES + 8, 1);
    chk("straps", {fs, baddr}, {1'b0, 8'hCE});
    // Output enables follow lock by one edge
    @(posedge pclk);
    chk("back", {fb, doe}, 20'hFFFFF);
    $display("power-down test done");
    end_of_test();
  end
endmodule

bind cbpc_top cbpc_monitor mon_u (.pclk, .presetn, .psel, .penable,
  .pready, .dif_fall, .diff_clock_out_oe, .feedback_clock_out_oe,
  .osc_run, .pll_locked, .bus_pins_oe, .freq_sel, .bus_addr);
